/* File: common/csbi_pkg.sv */
// Constants and carrier types for the console bus select and interrupt block.
// Assumes one 20 MHz clock; every system bus and terminal pin is asynchronous.
package csbi_pkg;

  // Wishbone byte offsets of the two words
  localparam logic [3:0] CSBI_CFG_OFS  = 4'h0;
  localparam logic [3:0] CSBI_STAT_OFS = 4'h4;

  // Configuration word fields
  localparam int CSBI_BASE_LSB = 0;
  localparam int CSBI_VEC_LSB  = 10;
  localparam int CSBI_INH_BIT  = 16;
  localparam int CSBI_HOLD_BIT = 17;
  localparam int CSBI_LOOP_BIT = 18;

  // Reset values: base pattern for A(12:3), vector jumpers for bits 8:3
  localparam logic [9:0]  CSBI_BASE_RST = 10'h3EE;
  localparam logic [5:0]  CSBI_VEC_RST  = 6'h06;
  localparam logic        CSBI_INH_RST  = 1'h0;
  localparam logic        CSBI_HOLD_RST = 1'h1;
  localparam logic        CSBI_LOOP_RST = 1'h0;
  localparam logic [31:0] CSBI_CFG_RST  = {13'h0000, CSBI_LOOP_RST, CSBI_HOLD_RST,
                                           CSBI_INH_RST, CSBI_VEC_RST, CSBI_BASE_RST};
  localparam logic [31:0] CSBI_CFG_MASK = 32'h0007FFFF;

  // Status word fields
  localparam int CSBI_ST_KDONE = 0;
  localparam int CSBI_ST_KIE   = 1;
  localparam int CSBI_ST_PRDY  = 2;
  localparam int CSBI_ST_PIE   = 3;
  localparam int CSBI_ST_ARMA  = 4;
  localparam int CSBI_ST_ARMB  = 5;
  localparam int CSBI_ST_V2    = 6;
  localparam int CSBI_ST_BUSY  = 7;

  // System bus decode
  localparam logic [4:0] CSBI_ADDR_TOP  = 5'h1F;
  localparam logic [1:0] CSBI_CTL_DATI  = 2'h0;
  localparam logic [1:0] CSBI_CTL_DATIP = 2'h1;
  localparam logic [1:0] CSBI_CTL_DATO  = 2'h2;
  localparam logic [1:0] CSBI_CTL_DATOB = 2'h3;
  localparam logic [6:0] CSBI_VEC_PAD   = 7'h00;
  localparam logic [1:0] CSBI_VEC_LOW   = 2'h0;

  // Asynchronous pins, sampled together
  typedef struct packed {
    logic [17:0] addr;         // Bus address
    logic [1:0]  ctrl;         // Bus control code
    logic        msyn;         // Master sync
    logic        data_ie;      // Bus data bit 6
    logic        ssyn;         // Slave sync line level
    logic        bbsy;         // Bus busy line level
    logic        bg;           // Incoming bus grant
    logic        npr;          // Non-processor request line
    logic        key_strobe_n; // Keycode latch pulse, low active
    logic        prt_req;      // Printer request level
  } csbi_pins_t;

  localparam csbi_pins_t CSBI_PINS_IDLE = '{addr: 18'h00000, ctrl: 2'h0, msyn: 1'h0,
                                            data_ie: 1'h0, ssyn: 1'h0, bbsy: 1'h0,
                                            bg: 1'h0, npr: 1'h0, key_strobe_n: 1'h1,
                                            prt_req: 1'h0};

  typedef enum {CSBI_IDLE, CSBI_REQ, CSBI_SACK, CSBI_MASTER} csbi_irq_state_t;

endpackage

/* File: logic/csbi_top.sv */
// Console bus select decode and two-channel vectored interrupt control.
// Assumes asynchronous bus pins and a Wishbone classic master for setup.
//
// How it works
// - Inhibit set means no slave sync answer
// - Address bits 2:1 pick select 0/2/4/6
// - Address bits 12:3 must equal base pattern
// - Default vectors are 060 and 064
// - Six jumper bits set vector bits 8:3
// - Installed jumper reads one, absent zero
// - Channel A requests on done and enable
// - Keyboard enable loads D06 on status write
// - Keycode latch pulse sets keyboard done
// - Loopback lets print strobe set done
// - Request and enable raise bus request
// - Grant gives SACK, then BBSY when idle
// - Printer status D06 write loads printer enable
// - Printer request rising edge sets printer ready
// - Keyboard channel wins over printer channel
// - Vector bit 2 low for A, high B
// - Grant passes through while not requesting
// - Release mastership on processor slave sync
// - No new request until condition drops
// - Hold sequence while jumper on and NPR
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module csbi_top
  import csbi_pkg::*;
(
  input  wire logic        clk_i,                    // 20 MHz clock
  input  wire logic        rst_i,                    // Sync reset, high
  input  wire logic        wb_cyc_i,                 // Wishbone cycle
  input  wire logic        wb_stb_i,                 // Wishbone strobe
  input  wire logic        wb_we_i,                  // Wishbone write
  input  wire logic [3:0]  wb_adr_i,                 // Byte address
  input  wire logic [31:0] wb_dat_i,                 // Write data
  input  wire logic [3:0]  wb_sel_i,                 // Byte enables
  output logic      [31:0] wb_dat_o,                 // Read data
  output logic             wb_ack_o,                 // Acknowledge
  input  wire csbi_pins_t  pins_i,                   // Async bus and terminal pins
  output logic      [3:0]  select_o,                 // Select lines 0/2/4/6
  output logic             gate_in_o,                // Read gating
  output logic             gate_out_low_o,           // Low byte write gating
  output logic             gate_out_high_o,          // High byte write gating
  output logic             print_strobe_o,           // Print command
  output logic             ssyn_o,                   // Slave sync value
  output logic             ssyn_oe_o,                // Slave sync drive
  output logic             br_o,                     // Bus request
  output logic             bg_out_o,                 // Outgoing grant
  output logic             sack_o,                   // Selection acknowledge
  output logic             bbsy_o,                   // Bus busy value
  output logic             bbsy_oe_o,                // Bus busy drive
  output logic             intr_o,                   // Vector strobe
  output logic      [15:0] data_o,                   // Vector data
  output logic             data_oe_o,                // Vector drive
  output logic             keyboard_done_o,          // Channel A request level
  output logic             printer_ready_o,          // Channel B request level
  output logic             channel_a_enable_level_o, // Channel A enable
  output logic             channel_b_enable_level_o  // Channel B enable
);

  function automatic logic [3:0] sel_decode(input logic [1:0] a);
    sel_decode = 4'h1 << a;
  endfunction

  // Three-stage sampling of all async pins
  csbi_pins_t s1_reg;
  csbi_pins_t s2_reg;
  csbi_pins_t s3_reg;
  csbi_pins_t pin_reg;
  csbi_pins_t pin_next;

  // A bit only changes once stages two and three agree
  assign pin_next = csbi_pins_t'((s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg)));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg  <= CSBI_PINS_IDLE;
      s2_reg  <= CSBI_PINS_IDLE;
      s3_reg  <= CSBI_PINS_IDLE;
      pin_reg <= CSBI_PINS_IDLE;
    end
    else
    begin
      s1_reg  <= pins_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  // Configuration and Wishbone slave
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [31:0] wr_mask;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [31:0] stat_w;
  logic        ack_reg;

  wire         wb_hit  = wb_cyc_i & wb_stb_i;
  wire         wb_wr   = wb_hit & ack_reg & wb_we_i & (wb_adr_i == CSBI_CFG_OFS);
  wire  [9:0]  cfg_base = cfg_reg[CSBI_BASE_LSB +: 10];
  wire  [5:0]  cfg_vec  = cfg_reg[CSBI_VEC_LSB +: 6];
  wire         cfg_inh  = cfg_reg[CSBI_INH_BIT];
  wire         cfg_hold = cfg_reg[CSBI_HOLD_BIT];
  wire         cfg_loop = cfg_reg[CSBI_LOOP_BIT];

  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      assign wr_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
  endgenerate

  // Write lands on the edge the master sees ack
  assign cfg_next = wb_wr ? (((cfg_reg & ~wr_mask) | (wb_dat_i & wr_mask)) & CSBI_CFG_MASK)
                          : cfg_reg;
  assign dat_next = (wb_adr_i == CSBI_CFG_OFS)  ? cfg_reg :
                    (wb_adr_i == CSBI_STAT_OFS) ? stat_w  : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_reg <= CSBI_CFG_RST;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      cfg_reg <= cfg_next;
      ack_reg <= wb_hit & ~ack_reg;
      dat_reg <= (wb_hit & ~ack_reg) ? dat_next : dat_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Address selection
  wire       addr_top = pin_reg.addr[17:13] == CSBI_ADDR_TOP;
  wire       addr_hit = addr_top & (pin_reg.addr[12:3] == cfg_base);
  wire       selected = pin_reg.msyn & addr_hit;
  wire [3:0] sel_w    = selected ? sel_decode(pin_reg.addr[2:1]) : 4'h0;
  wire       rd_cyc   = (pin_reg.ctrl == CSBI_CTL_DATI) | (pin_reg.ctrl == CSBI_CTL_DATIP);
  wire       byte_wr  = pin_reg.ctrl == CSBI_CTL_DATOB;
  wire       odd      = pin_reg.addr[0];
  wire       in_w     = selected & rd_cyc;
  wire       olow_w   = selected & ~rd_cyc & ~(byte_wr & odd);
  wire       ohigh_w  = selected & ~rd_cyc & ~(byte_wr & ~odd);
  wire       ssyn_w   = selected & ~cfg_inh;
  wire       print_w  = sel_w[3] & olow_w;

  logic [3:0] select_reg;
  logic       in_reg;
  logic       olow_reg;
  logic       ohigh_reg;
  logic       ssyn_reg;
  logic       print_reg;

  // Actions fire once per bus cycle, on the strobe's leading edge
  wire kie_load   = sel_w[0] & olow_w & ~(select_reg[0] & olow_reg);
  wire pie_load   = sel_w[2] & olow_w & ~(select_reg[2] & olow_reg);
  wire kbb_read   = sel_w[1] & in_w & ~(select_reg[1] & in_reg);
  wire print_edge = print_w & ~print_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      select_reg <= 4'h0;
      in_reg     <= 1'b0;
      olow_reg   <= 1'b0;
      ohigh_reg  <= 1'b0;
      ssyn_reg   <= 1'b0;
      print_reg  <= 1'b0;
    end
    else
    begin
      select_reg <= sel_w;
      in_reg     <= in_w;
      olow_reg   <= olow_w;
      ohigh_reg  <= ohigh_w;
      ssyn_reg   <= ssyn_w;
      print_reg  <= print_w;
    end
  end

  assign select_o        = select_reg;
  assign gate_in_o       = in_reg;
  assign gate_out_low_o  = olow_reg;
  assign gate_out_high_o = ohigh_reg;
  assign ssyn_o          = ssyn_reg;
  assign ssyn_oe_o       = ssyn_reg;
  assign print_strobe_o  = print_reg;

  // Keyboard and printer flags
  logic kdone_reg;
  logic kie_reg;
  logic prdy_reg;
  logic pie_reg;
  logic key_prev_reg;
  logic preq_prev_reg;

  wire key_pulse = key_prev_reg & ~pin_reg.key_strobe_n;
  wire preq_rise = pin_reg.prt_req & ~preq_prev_reg;
  // Set wins over the clear from a buffer read or print command
  wire kdone_next = key_pulse | (cfg_loop & print_edge) | (kdone_reg & ~kbb_read);
  wire prdy_next  = preq_rise | (prdy_reg & ~print_edge);
  wire kie_next   = kie_load ? pin_reg.data_ie : kie_reg;
  wire pie_next   = pie_load ? pin_reg.data_ie : pie_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      kdone_reg     <= 1'b0;
      kie_reg       <= 1'b0;
      prdy_reg      <= 1'b0;
      pie_reg       <= 1'b0;
      key_prev_reg  <= 1'b1;
      preq_prev_reg <= 1'b0;
    end
    else
    begin
      kdone_reg     <= kdone_next;
      kie_reg       <= kie_next;
      prdy_reg      <= prdy_next;
      pie_reg       <= pie_next;
      key_prev_reg  <= pin_reg.key_strobe_n;
      preq_prev_reg <= pin_reg.prt_req;
    end
  end

  assign keyboard_done_o          = kdone_reg;
  assign printer_ready_o          = prdy_reg;
  assign channel_a_enable_level_o = kie_reg;
  assign channel_b_enable_level_o = pie_reg;

  // Interrupt master sequence
  csbi_irq_state_t state_reg;
  csbi_irq_state_t state_next;
  logic            arm_a_reg;
  logic            arm_b_reg;
  logic            v2_reg;
  logic            v2_next;
  logic            br_reg;
  logic            bgo_reg;
  logic            sack_reg;
  logic            bbsy_reg;
  logic     [15:0] data_reg;

  wire cond_a   = kdone_reg & kie_reg;
  wire cond_b   = prdy_reg & pie_reg;
  wire want_a   = cond_a & arm_a_reg;
  wire want_b   = cond_b & arm_b_reg;
  wire want_any = want_a | want_b;
  wire bus_free = ~pin_reg.bbsy & ~pin_reg.ssyn & ~pin_reg.bg;
  wire npr_wait = cfg_hold & pin_reg.npr;
  wire release_w = (state_reg == CSBI_MASTER) & pin_reg.ssyn;
  // Channel disarms on release and rearms only once its condition drops
  wire arm_a_next = ~cond_a | (arm_a_reg & ~(release_w & ~v2_reg));
  wire arm_b_next = ~cond_b | (arm_b_reg & ~(release_w & v2_reg));

  always_comb
  begin
    state_next = state_reg;
    v2_next    = v2_reg;
    unique case (state_reg)
      CSBI_IDLE:
        if (want_any)
          state_next = CSBI_REQ;
      CSBI_REQ:
        if (!want_any)
          state_next = CSBI_IDLE;
        else if (pin_reg.bg)
        begin
          state_next = CSBI_SACK;
          v2_next    = ~want_a;
        end
      CSBI_SACK:
        if (bus_free && !npr_wait)
          state_next = CSBI_MASTER;
      CSBI_MASTER:
        if (pin_reg.ssyn)
          state_next = CSBI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= CSBI_IDLE;
      arm_a_reg <= 1'b1;
      arm_b_reg <= 1'b1;
      v2_reg    <= 1'b0;
      br_reg    <= 1'b0;
      bgo_reg   <= 1'b0;
      sack_reg  <= 1'b0;
      bbsy_reg  <= 1'b0;
      data_reg  <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      arm_a_reg <= arm_a_next;
      arm_b_reg <= arm_b_next;
      v2_reg    <= v2_next;
      br_reg    <= state_next == CSBI_REQ;
      bgo_reg   <= (state_next == CSBI_IDLE) & pin_reg.bg;
      sack_reg  <= state_next == CSBI_SACK;
      bbsy_reg  <= state_next == CSBI_MASTER;
      data_reg  <= {CSBI_VEC_PAD, cfg_vec, v2_next, CSBI_VEC_LOW};
    end
  end

  // Vector lines only driven while master; bits 1:0 driven as zero
  assign br_o      = br_reg;
  assign bg_out_o  = bgo_reg;
  assign sack_o    = sack_reg;
  assign bbsy_o    = bbsy_reg;
  assign bbsy_oe_o = bbsy_reg;
  assign intr_o    = bbsy_reg;
  assign data_o    = data_reg;
  assign data_oe_o = bbsy_reg;

  always_comb
  begin
    stat_w                = 32'h00000000;
    stat_w[CSBI_ST_KDONE] = kdone_reg;
    stat_w[CSBI_ST_KIE]   = kie_reg;
    stat_w[CSBI_ST_PRDY]  = prdy_reg;
    stat_w[CSBI_ST_PIE]   = pie_reg;
    stat_w[CSBI_ST_ARMA]  = arm_a_reg;
    stat_w[CSBI_ST_ARMB]  = arm_b_reg;
    stat_w[CSBI_ST_V2]    = v2_reg;
    stat_w[CSBI_ST_BUSY]  = state_reg != CSBI_IDLE;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  inhibit_ack_a: assert property ((cfg_inh && $past(cfg_inh)) |-> !ssyn_oe_o)
    else $error("slave sync driven while inhibited");

  select_dec_a: assert property (
    (selected && pin_reg.addr[2:1] == 2'h2) |=> select_o == 4'h4)
    else $error("select line decode wrong");

  base_match_a: assert property (
    (select_o != 4'h0) |-> $past(pin_reg.addr[12:3] == cfg_base && addr_top))
    else $error("select without base match");

  byte_gate_a: assert property (
    (selected && byte_wr && odd) |=> gate_out_high_o && !gate_out_low_o)
    else $error("odd byte write gating wrong");

  vector_val_a: assert property (
    $rose(data_oe_o) |-> data_o[1:0] == 2'h0 && data_o[8:3] == $past(cfg_vec))
    else $error("vector bits wrong");

  key_done_a: assert property (key_pulse |=> keyboard_done_o)
    else $error("keycode pulse lost");

  loop_set_a: assert property ((print_edge && cfg_loop) |=> keyboard_done_o)
    else $error("loopback did not set done");

  kie_load_a: assert property (kie_load |=> kie_reg == $past(pin_reg.data_ie))
    else $error("keyboard enable load wrong");

  pie_load_a: assert property (pie_load |=> pie_reg == $past(pin_reg.data_ie))
    else $error("printer enable load wrong");

  req_cause_a: assert property ($rose(br_o) |-> $past(want_any))
    else $error("bus request without cause");

  prio_pick_a: assert property (
    (state_reg == CSBI_REQ && pin_reg.bg && want_a) |=> !data_o[2] ##0 sack_o)
    else $error("keyboard did not win");

  bbsy_gate_a: assert property (
    $rose(bbsy_o) |-> $past(bus_free && !npr_wait))
    else $error("bus taken while not free");

  npr_hold_a: assert property (
    (state_reg == CSBI_SACK && npr_wait) |=> !bbsy_o)
    else $error("sequence ran during NPR");

  grant_pass_a: assert property (
    (state_reg == CSBI_IDLE && !want_any && pin_reg.bg) |=> bg_out_o)
    else $error("grant not passed through");

  // Only the other channel may request right after a release
  release_a: assert property (release_w |=> !bbsy_o && !data_oe_o
    ##1 (!br_o || $past(v2_reg ? want_a : want_b)))
    else $error("bus not released");

  rearm_a: assert property ((release_w && !v2_reg && cond_a) |=> !arm_a_reg)
    else $error("channel A rearmed too soon");

endmodule

/* File: test/csbi_cpu_model.sv */
// Processor and arbiter model: grants requests, strobes in the vector.
// Assumes the bench forms wire levels from both parties' drives.
`timescale 1ns/1ns
module csbi_cpu_model
  import csbi_pkg::*;
(
  input  wire logic        clk_i,    // Bench clock
  input  wire logic        rst_i,    // Sync reset
  input  wire logic        br_i,     // Bus request seen
  input  wire logic        sack_i,   // Selection ack seen
  input  wire logic        bbsy_i,   // Bus busy wire
  input  wire logic [15:0] data_i,   // Data lines
  input  wire logic [7:0]  delay_i,  // Grant latency, cycles
  output logic             bg_o,     // Bus grant
  output logic             ssyn_o,   // Slave sync drive
  output logic      [15:0] vec_o,    // Last vector taken
  output logic      [7:0]  vec_cnt_o // Vectors taken
);
  logic [7:0] wait_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bg_o      <= 1'h0;
      ssyn_o    <= 1'h0;
      wait_reg  <= 8'h00;
      vec_o     <= 16'h0000;
      vec_cnt_o <= 8'h00;
    end
    else
    begin
      // Grant held until selection ack, as an arbiter would
      if (sack_i || !br_i)
      begin
        bg_o     <= 1'h0;
        wait_reg <= 8'h00;
      end
      else if (wait_reg >= delay_i)
        bg_o <= 1'h1;
      else
        wait_reg <= wait_reg + 8'h01;
      // Latch the vector and answer on the same edge
      if (bbsy_i && !ssyn_o)
      begin
        vec_o     <= data_i;
        ssyn_o    <= 1'h1;
        vec_cnt_o <= vec_cnt_o + 8'h01;
      end
      else if (!bbsy_i)
        ssyn_o <= 1'h0;
    end
  end
endmodule

/* File: test/tb.sv */
// Self-checking bench for the bus select and interrupt block.
// Assumes the processor model answers the master side.
`timescale 1ns/1ns
module tb;
  import csbi_pkg::*;
  logic        clk_i = 1'h0, rst_i = 1'h1;
  logic        cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [3:0]  adr = 4'h0, sel = 4'h0, sel_s;
  logic [31:0] wdat = 32'h0, rd, wb_dat_o;
  logic [17:0] addr = 18'h0;
  logic [1:0]  ctrl = 2'h0;
  logic        msyn = 1'h0, d6 = 1'h0, npr = 1'h0, ks_n = 1'h1, prq = 1'h0, bg_x = 1'h0;
  logic [9:0]  base_v = CSBI_BASE_RST;
  logic [7:0]  gdly = 8'h03, vec_cnt;
  logic [2:0]  gt_s;
  logic        ss_s, ps_s, wb_ack_o, gate_in_o, gate_out_low_o, gate_out_high_o, print_strobe_o;
  logic        ssyn_o, ssyn_oe_o, br_o, bg_out_o, sack_o, bbsy_o, bbsy_oe_o, intr_o;
  logic        data_oe_o, keyboard_done_o, printer_ready_o, cpu_bg, cpu_ssyn;
  logic        channel_a_enable_level_o, channel_b_enable_level_o;
  logic [15:0] data_o, vec;
  logic [3:0]  select_o;
  csbi_pins_t  pins;
  int          fail_count = 0, cmp_count = 0, cycles = 0;

  always #25 clk_i = ~clk_i;
  // Open-drain wires: either party pulls them
  assign pins = '{addr: addr, ctrl: ctrl, msyn: msyn, data_ie: d6, ssyn: cpu_ssyn | ssyn_oe_o,
                  bbsy: bbsy_oe_o, bg: cpu_bg | bg_x, npr: npr, key_strobe_n: ks_n,
                  prt_req: prq};

  csbi_top csbi_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pins_i(pins), .select_o(select_o), .gate_in_o(gate_in_o),
    .gate_out_low_o(gate_out_low_o), .gate_out_high_o(gate_out_high_o),
    .print_strobe_o(print_strobe_o), .ssyn_o(ssyn_o), .ssyn_oe_o(ssyn_oe_o), .br_o(br_o),
    .bg_out_o(bg_out_o), .sack_o(sack_o), .bbsy_o(bbsy_o), .bbsy_oe_o(bbsy_oe_o),
    .intr_o(intr_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .keyboard_done_o(keyboard_done_o), .printer_ready_o(printer_ready_o),
    .channel_a_enable_level_o(channel_a_enable_level_o),
    .channel_b_enable_level_o(channel_b_enable_level_o));

  csbi_cpu_model csbi_cpu_model_i (.clk_i(clk_i), .rst_i(rst_i), .br_i(br_o),
    .sack_i(sack_o), .bbsy_i(bbsy_oe_o), .data_i(data_o), .delay_i(gdly), .bg_o(cpu_bg),
    .ssyn_o(cpu_ssyn), .vec_o(vec), .vec_cnt_o(vec_cnt));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
  endtask

  // One slave cycle; outputs sampled mid-cycle once settled
  task automatic sbus(input logic [2:0] lo, input logic [1:0] c, input logic d);
    @(posedge clk_i);
    addr <= {CSBI_ADDR_TOP, base_v, lo};
    ctrl <= c;
    d6   <= d;
    @(posedge clk_i);
    msyn <= 1'h1;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    sel_s = select_o;
    gt_s  = {gate_in_o, gate_out_high_o, gate_out_low_o};
    ss_s  = ssyn_oe_o;
    ps_s  = print_strobe_o;
    @(posedge clk_i);
    msyn <= 1'h0;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic kstrobe();
    @(posedge clk_i);
    ks_n <= 1'h0;
    repeat (3) @(posedge clk_i);
    ks_n <= 1'h1;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic serve(input logic [15:0] exp);
    logic [7:0] c0;
    int         n;
    c0 = vec_cnt;
    n  = 0;
    while (vec_cnt == c0 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(vec_cnt), 32'(c0 + 8'h01), "vector taken");
    chk(32'(vec), 32'(exp), "vector");
    repeat (10) @(posedge clk_i);
    chk(32'({bbsy_oe_o, intr_o, data_oe_o}), 32'h0, "bus release");
  endtask

  task automatic t_reset();
    chk(32'({br_o, bbsy_oe_o, sack_o, select_o}), 32'h0, "reset outputs");
    wb(1'h0, CSBI_CFG_OFS, 32'h0, rd);
    chk(rd, CSBI_CFG_RST, "config reset");
    wb(1'h1, 4'hC, 32'hFFFFFFFF, rd);
    wb(1'h0, 4'hC, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    wb(1'h0, CSBI_STAT_OFS, 32'h0, rd);
    chk(rd & 32'h0000000F, 32'h0, "status reset");
  endtask

  task automatic t_decode();
    logic [1:0] c;
    logic [2:0] g;
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 8; j++)
      begin
        c = j[2:1];
        sbus({i[1:0], j[0]}, c, 1'h0);
        g = (c == CSBI_CTL_DATO) ? 3'h3 : (c == CSBI_CTL_DATOB) ? (j[0] ? 3'h2 : 3'h1) : 3'h4;
        chk(32'(sel_s), 32'(4'h1 << i), "select line");
        chk(32'(ss_s), 32'h1, "slave ack");
        chk(32'(gt_s), 32'(g), "gating");
        chk(32'(ps_s), 32'(i == 3 && g[0]), "print strobe");
      end
    base_v = CSBI_BASE_RST ^ 10'h001;
    sbus(3'h0, CSBI_CTL_DATI, 1'h0);
    chk(32'({sel_s, ss_s}), 32'h0, "foreign address");
    base_v = CSBI_BASE_RST;
    wb(1'h1, CSBI_CFG_OFS, CSBI_CFG_RST | 32'h00010000, rd);
    sbus(3'h4, CSBI_CTL_DATI, 1'h0);
    chk(32'(sel_s), 32'h4, "inhibited select");
    chk(32'(ss_s), 32'h0, "inhibited ack");
    wb(1'h1, CSBI_CFG_OFS, CSBI_CFG_RST, rd);
  endtask

  task automatic t_grant();
    bg_x <= 1'h1;
    repeat (8) @(posedge clk_i);
    chk(32'({bg_out_o, sack_o}), 32'h2, "grant passed");
    bg_x <= 1'h0;
    repeat (8) @(posedge clk_i);
    chk(32'(bg_out_o), 32'h0, "grant dropped");
  endtask

  task automatic t_irq_kbd();
    gdly <= 8'h3C;
    sbus(3'h0, CSBI_CTL_DATO, 1'h1);
    chk(32'({channel_a_enable_level_o, channel_b_enable_level_o}), 32'h2, "kbd enable");
    kstrobe();
    chk(32'(keyboard_done_o), 32'h1, "keyboard_done_flop");
    chk(32'(br_o), 32'h1, "bus request");
    serve(16'h0030);
    repeat (20) @(posedge clk_i);
    chk(32'(br_o), 32'h0, "no rerequest");
    wb(1'h1, CSBI_CFG_OFS, CSBI_CFG_RST | 32'h0000FC00, rd);
    sbus(3'h2, CSBI_CTL_DATI, 1'h0);
    kstrobe();
    serve(16'h01F8);
    wb(1'h1, CSBI_CFG_OFS, CSBI_CFG_RST, rd);
  endtask

  task automatic t_irq_both();
    sbus(3'h2, CSBI_CTL_DATI, 1'h0);
    sbus(3'h4, CSBI_CTL_DATO, 1'h1);
    chk(32'(channel_b_enable_level_o), 32'h1, "prt enable");
    prq <= 1'h1;
    kstrobe();
    chk(32'(printer_ready_o), 32'h1, "prt ready");
    serve(16'h0030);
    serve(16'h0034);
    sbus(3'h6, CSBI_CTL_DATO, 1'h0);
    prq <= 1'h0;
  endtask

  task automatic t_loop_npr();
    gdly <= 8'h03;
    wb(1'h1, CSBI_CFG_OFS, CSBI_CFG_RST | 32'h00040000, rd);
    sbus(3'h2, CSBI_CTL_DATI, 1'h0);
    chk(32'(keyboard_done_o), 32'h0, "done cleared");
    npr <= 1'h1;
    sbus(3'h6, CSBI_CTL_DATO, 1'h0);
    chk(32'(keyboard_done_o), 32'h1, "loopback done");
    repeat (30) @(posedge clk_i);
    chk(32'(bbsy_oe_o), 32'h0, "held by npr");
    npr <= 1'h0;
    serve(16'h0030);
    wb(1'h1, CSBI_CFG_OFS, CSBI_CFG_RST, rd);
  endtask

  // Whole run needs about a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_decode();
    t_grant();
    t_irq_kbd();
    t_irq_both();
    t_loop_npr();
    finish_test();
  end
endmodule
